// >>> scw_pkg.sv
/*
  scw_pkg: constants shared by the serial control word link, the receiver end
  and the host end.
  assumes: both ends run on clk_sys at 25 MHz.
*/
package scw_pkg;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int CTRL_POS = 12;
  localparam int CTRL_BITS = 4;
  localparam int ADDR_POS = 8;
  localparam int ADDR_BITS = 4;
  localparam int DATA_POS = 0;
  localparam int DATA_BITS = 8;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // host shift clock: half period in clk_sys cycles (25 MHz / 8 = 3.125 MHz, under 40 MHz)
  localparam int SYS_CLK_MHZ = 25;
  localparam int SCK_MAX_MHZ = 40;
  localparam int SCK_HALF_CYC_CALC = (SYS_CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
  localparam logic [3:0] SCK_HALF_CYC = 4'h4;
  localparam logic [3:0] BYTE_GAP_CYC = 4'h8;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
endpackage : scw_pkg

// >>> scw_if.sv
/*
  scw_if: three wire serial link, shift clock, active-low frame and data.
  assumes: host drives all three wires, the receiver only listens.
*/
`timescale 1ns/1ps
interface scw_if;
  logic shift_clk;
  logic frame_select_n;
  logic serial_data_in;
  modport host (output shift_clk, output frame_select_n, output serial_data_in);
  modport receiver (input shift_clk, input frame_select_n, input serial_data_in);
endinterface : scw_if

// >>> scw_sync.sv
/*
  scw_sync: two flip-flop synchroniser for one level.
  assumes: d comes from outside the clk_sys domain.
*/
`timescale 1ns/1ps
module scw_sync (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic d,
  output logic q
);
  logic meta;
  logic next_meta;
  logic next_q;

  // first stage is read only by the second stage
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // both stages reset high: matches the idle level of clock and frame, so no false edge after reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : scw_sync

// >>> scw_receiver.sv
/*
  scw_receiver: receiving end of the serial control word link. Captures a
  16-bit word, msb first, on falling shift clock edges while the frame is low,
  and presents it split into control, address and data with a load pulse.
  assumes: shift clock well below clk_sys/4 so every edge is seen after sync;
  the host keeps its own obligations on clock rate, bit order and framing.
*/
// Summary of operation
// - host shift clock at most 40 MHz
// - any shift clock idle level works
// - host holds frame low for 16 bits
// - one low frame carries one word
// - sample data on falling clock edges
// - host changes data on rising edges
// - host sends most significant bit first
// - word splits control, address, data fields
// - two byte transfers build one word
// - frame rises only after second byte
// - shift clock high between byte transfers
// - lsb-first hosts reverse bits beforehand
// - active-high frame hosts invert it
// - one frame per written word
`timescale 1ns/1ps
module scw_receiver
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  scw_if.receiver link,
  output logic [3:0] word_ctrl,
  output logic [3:0] word_addr,
  output logic [7:0] word_data,
  output logic word_load
);
  logic sck_s;
  logic fs_n_s;
  logic sd_s;
  logic sck_d;
  logic [15:0] shift;
  logic [4:0] bit_cnt;
  logic next_sck_d;
  logic [15:0] next_shift;
  logic [4:0] next_bit_cnt;
  logic [3:0] next_word_ctrl;
  logic [3:0] next_word_addr;
  logic [7:0] next_word_data;
  logic next_word_load;
  logic fall;

  // all three wires pass the same two stages, so data stays aligned with the clock edge
  scw_sync u_sync_sck (.clk_sys(clk_sys), .rstn(rstn), .d(link.shift_clk), .q(sck_s));
  scw_sync u_sync_fs (.clk_sys(clk_sys), .rstn(rstn), .d(link.frame_select_n), .q(fs_n_s));
  scw_sync u_sync_sd (.clk_sys(clk_sys), .rstn(rstn), .d(link.serial_data_in), .q(sd_s));

  // edge detect works on synced clock only, so idle level does not matter
  assign fall = sck_d & ~sck_s;

  // capture and word assembly
  always_comb begin
    next_sck_d = sck_s;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_word_ctrl = word_ctrl;
    next_word_addr = word_addr;
    next_word_data = word_data;
    next_word_load = 1'b0;
    if (fs_n_s) begin
      // frame high: drop any partial word, start clean next frame
      next_bit_cnt = BIT_CNT_RESET;
    end else if (fall && bit_cnt < 5'(WORD_BITS)) begin
      // shift in msb first; byte gap just pauses the count
      next_shift = {shift[14:0], sd_s};
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(WORD_BITS - 1)) begin
        // sixteenth bit closes the word; further edges ignored till frame ends
        next_word_ctrl = next_shift[CTRL_POS +: CTRL_BITS];
        next_word_addr = next_shift[ADDR_POS +: ADDR_BITS];
        next_word_data = next_shift[DATA_POS +: DATA_BITS];
        next_word_load = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_d <= 1'b1;
      shift <= WORD_RESET;
      bit_cnt <= BIT_CNT_RESET;
      word_ctrl <= 4'h0;
      word_addr <= 4'h0;
      word_data <= 8'h00;
      word_load <= 1'b0;
    end else begin
      sck_d <= next_sck_d;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      word_ctrl <= next_word_ctrl;
      word_addr <= next_word_addr;
      word_data <= next_word_data;
      word_load <= next_word_load;
    end
  end
endmodule : scw_receiver

// >>> scw_host.sv
/*
  scw_host: sending end of the serial control word link. Takes a 16-bit word
  and shifts it out msb first under one low frame, optionally as two bytes
  with the shift clock held high in the gap.
  assumes: user holds send_word stable while send_req is high.
*/
`timescale 1ns/1ps
module scw_host
  import scw_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  scw_if.host link,
  input wire logic send_req,
  input wire logic [15:0] send_word,
  input wire logic split_bytes,
  output logic busy,
  output logic done
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_GAP = 4'b0100,
    ST_END = 4'b1000
  } host_state_t;

  host_state_t state;
  host_state_t next_state;
  logic [15:0] shift;
  logic [15:0] next_shift;
  logic [4:0] bits_left;
  logic [4:0] next_bits_left;
  logic [3:0] tick;
  logic [3:0] next_tick;
  logic sck;
  logic next_sck;
  logic fs_n;
  logic next_fs_n;
  logic split;
  logic next_split;
  logic next_busy;
  logic next_done;

  assign link.shift_clk = sck;
  assign link.frame_select_n = fs_n;
  assign link.serial_data_in = shift[15]; // msb first

  // sequencer: clock idles high, data moves on rising edges
  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bits_left = bits_left;
    next_tick = tick;
    next_sck = sck;
    next_fs_n = fs_n;
    next_split = split;
    next_busy = busy;
    next_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (send_req) begin
          next_shift = send_word;
          next_split = split_bytes;
          next_bits_left = 5'(WORD_BITS);
          next_fs_n = 1'b0; // one frame per word
          next_tick = SCK_HALF_CYC;
          next_busy = 1'b1;
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // half period of 4 cycles gives 3.125 MHz, inside the limit
        if (tick != 4'h1) begin
          next_tick = tick - 4'h1;
        end else begin
          next_tick = SCK_HALF_CYC;
          next_sck = ~sck;
          if (!sck) begin
            // rising edge: advance data after the falling edge used it
            next_shift = {shift[14:0], 1'b0};
            if (bits_left == 5'h00) begin
              next_state = ST_END;
            end else if (split && bits_left == 5'(BYTE_BITS)) begin
              next_tick = BYTE_GAP_CYC;
              next_state = ST_GAP; // clock held high, frame stays low
            end
          end else begin
            next_bits_left = bits_left - 5'h01;
          end
        end
      end
      ST_GAP: begin
        if (tick != 4'h1) begin
          next_tick = tick - 4'h1;
        end else begin
          next_tick = SCK_HALF_CYC;
          next_state = ST_SHIFT;
        end
      end
      ST_END: begin
        // frame rises only after all 16 falling edges
        next_fs_n = 1'b1;
        next_busy = 1'b0;
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_fs_n = 1'b1;
        next_sck = 1'b1;
        next_busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      shift <= WORD_RESET;
      bits_left <= BIT_CNT_RESET;
      tick <= 4'h0;
      sck <= 1'b1;
      fs_n <= 1'b1;
      split <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bits_left <= next_bits_left;
      tick <= next_tick;
      sck <= next_sck;
      fs_n <= next_fs_n;
      split <= next_split;
      busy <= next_busy;
      done <= next_done;
    end
  end
endmodule : scw_host

// >>> scw_properties.sv
/* scw_properties: timing checks on the link between the two ends.
   assumes: the host end drives the link from clk_sys. */
`timescale 1ns/1ps
module scw_properties (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic shift_clk,
  input wire logic frame_select_n,
  input wire logic serial_data_in,
  input wire logic word_load,
  input wire logic busy,
  input wire logic done
);
  logic sck_q;
  logic [4:0] falls;
  logic [4:0] next_falls;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // falling shift clock edges in the current frame, cleared while the frame is high
  always_comb begin
    next_falls = frame_select_n ? 5'h00 : falls + {4'h0, sck_q & ~shift_clk};
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sck_q <= 1'b1;
      falls <= 5'h00;
    end else begin
      sck_q <= shift_clk;
      falls <= next_falls;
    end
  end
  frame_tracks_busy_a: assert property (busy == !frame_select_n)
    else $error("frame low does not match busy");
  frame_end_done_a: assert property ($rose(frame_select_n) |-> done && falls == 5'h10)
    else $error("frame ended early or without done");
  load_count_a: assert property (word_load |-> falls == 5'h10 && !frame_select_n)
    else $error("load without sixteen falls");
  load_pulse_a: assert property (word_load |=> !word_load)
    else $error("load longer than one cycle");
  data_hold_a: assert property ($fell(shift_clk) |-> $stable(serial_data_in))
    else $error("data moved at falling edge");
  data_move_a: assert property (!frame_select_n && !$past(frame_select_n) && $changed(serial_data_in)
    |-> $rose(shift_clk))
    else $error("data moved away from rising edge");
  low_phase_a: assert property ($fell(shift_clk) |-> !shift_clk [*4] ##1 shift_clk)
    else $error("clock low phase wrong");
  idle_high_a: assert property (frame_select_n |-> shift_clk)
    else $error("clock not high while idle");
  cover property (word_load);
  cover property ($rose(frame_select_n));
  cover property ((falls == 5'h08 && shift_clk && !frame_select_n) [*8]);
endmodule : scw_properties

// >>> tb_top.sv
/* tb_top: host end against receiver end, and a bench-driven second link.
   assumes: clk_sys at 25 MHz, link clock of 320 ns on the second link. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic send_req = 1'b0;
  logic [15:0] send_word = 16'h0000;
  logic split_bytes = 1'b0;
  logic busy, done, word_load, load_b;
  logic [3:0] word_ctrl, word_addr, ctrl_b, addr_b;
  logic [7:0] word_data, data_b;
  int fails = 0;
  int n_compared = 0;
  int loads_a = 0;
  int loads_b = 0;
  scw_if link_a ();
  scw_if link_b ();
  always #20 clk_sys = ~clk_sys;
  scw_host scw_host_i (.clk_sys(clk_sys), .rstn(rstn), .link(link_a.host), .send_req(send_req),
    .send_word(send_word), .split_bytes(split_bytes), .busy(busy), .done(done));
  scw_receiver scw_receiver_i (.clk_sys(clk_sys), .rstn(rstn), .link(link_a.receiver),
    .word_ctrl(word_ctrl), .word_addr(word_addr), .word_data(word_data), .word_load(word_load));
  scw_receiver scw_receiver_b_i (.clk_sys(clk_sys), .rstn(rstn), .link(link_b.receiver),
    .word_ctrl(ctrl_b), .word_addr(addr_b), .word_data(data_b), .word_load(load_b));
  scw_properties scw_properties_i (.clk_sys(clk_sys), .rstn(rstn), .shift_clk(link_a.shift_clk),
    .frame_select_n(link_a.frame_select_n), .serial_data_in(link_a.serial_data_in),
    .word_load(word_load), .busy(busy), .done(done));
  // load pulses counted so missing or extra loads show up
  always @(posedge clk_sys) begin
    loads_a <= loads_a + int'(word_load === 1'b1);
    loads_b <= loads_b + int'(load_b === 1'b1);
  end
  task finish_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test
  task check_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  // one request, held one cycle; a refused one would show as a timeout
  task host_send(input logic [15:0] w, input logic s);
    int n;
    n = loads_a;
    send_req = 1'b1;
    send_word = w;
    split_bytes = s;
    @(negedge clk_sys);
    send_req = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk_sys);
    if (done !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: host transfer did not finish", $time);
      finish_test();
    end
    check_val({word_ctrl, word_addr, word_data}, w);
    check_val(16'(loads_a - n), 16'h0001);
  endtask : host_send
  // shift nbits msb first, data moved on rising edges, half period 4 cycles
  task bang(input logic [15:0] w, input int nbits, input logic idle);
    link_b.frame_select_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    for (int i = 15; i > 15 - nbits; i--) begin
      link_b.shift_clk = 1'b1;
      link_b.serial_data_in = w[i];
      repeat (4) @(negedge clk_sys);
      link_b.shift_clk = 1'b0;
      repeat (4) @(negedge clk_sys);
    end
    link_b.shift_clk = idle;
    repeat (4) @(negedge clk_sys);
    link_b.frame_select_n = 1'b1;
    link_b.serial_data_in = ~link_b.serial_data_in;
    repeat (4) @(negedge clk_sys);
  endtask : bang
  task scen_host_words;
    host_send(16'hA5C3, 1'b0);
    host_send(16'h3C96, 1'b1);
  endtask : scen_host_words
  task scen_short_frame;
    int n;
    n = loads_b;
    bang(16'h5A0F, 16, 1'b1);
    check_val({ctrl_b, addr_b, data_b}, 16'h5A0F);
    bang(16'hFFFF, 10, 1'b1);
    check_val({ctrl_b, addr_b, data_b}, 16'h5A0F);
    link_b.shift_clk = 1'b0;
    repeat (4) @(negedge clk_sys);
    bang(16'h81E7, 16, 1'b0);
    check_val({ctrl_b, addr_b, data_b}, 16'h81E7);
    check_val(16'(loads_b - n), 16'h0002);
  endtask : scen_short_frame
  initial begin
    link_b.shift_clk = 1'b1;
    link_b.frame_select_n = 1'b1;
    link_b.serial_data_in = 1'b0;
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    scen_host_words();
    scen_short_frame();
    finish_test();
  end
endmodule : tb_top
